// [verilog/adc_rate_and_vref_config.sv]
/*
 * Rate and reference configuration of a delta-sigma converter: two
 * registers written by serial register commands, their decoded controls,
 * and the conversion sequencer they steer (rate, mode, chop, restart).
 * Assumes the command decoder gives one-cycle write and read strobes in
 * the clk domain, and the oscillator paths give one-cycle modulator ticks.
 */
// Behaviour
// (R1) Chop on: swap inputs each conversion, output average of each reading pair.
// (R2) Clock select 0 uses internal 4.096 MHz oscillator, 1 external clock.
// (R3) Mode bit 0 continuous conversions, 1 single-shot.
// (R4) Filter bit 0 third-order sinc, 1 low-latency filter (default).
// (R5) Rate code bits 3:0 picks data rate; 0000 is 2.5 SPS, default 20 SPS.
// (R6) Monitor code: off, low 0.3 V, plus third-span, or low plus pull-together.
// (R7) Positive buffer bit 5: 0 active (default), 1 bypassed.
// (R8) Negative buffer bit 4: 0 active, 1 bypassed (default).
// (R9) Source code: pair 0, pair 1, internal 2.5 V, 11 reserved.
// (R10) Power code: off, on but sleeps in power-down, always on, 11 reserved.
// (R11) Host turns internal source on before using excitation current sources.
// (R12) Host should bypass both buffers when internal source is selected.
// (R13) Configuration write resets filter, restarts conversion after programmed delay; the code does so only when a running conversion sees a changed value.
// (R14) Registers read back last write, reserved codes too; defaults on reset.
`timescale 1ns/1ps

module adc_rate_and_vref_config #(
    parameter int DATA_W = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    // Register command port
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [adc_cfg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Conversion control
    input wire logic conv_start,
    input wire logic conv_stop,
    input wire logic power_down,
    input wire logic [2:0] conv_delay_code,
    input wire logic internal_mod_tick,
    input wire logic external_mod_tick,
    input wire logic signed [DATA_W-1:0] filter_data,
    output logic external_clock_select,
    output logic low_latency_filter,
    output logic filter_reset,
    output logic input_swap,
    output logic converting,
    output logic data_ready,
    output logic signed [DATA_W-1:0] conv_data,
    // Reference controls
    output logic low_threshold_monitor,
    output logic third_span_monitor,
    output logic pull_together_enable,
    output logic positive_buffer_bypass,
    output logic negative_buffer_bypass,
    output logic ref_pair0_select,
    output logic ref_pair1_select,
    output logic internal_ref_select,
    output logic internal_source_on
);

    logic [7:0] sample_rate_config;
    logic [7:0] voltage_source_control;
    logic [7:0] next_sample_rate_config;
    logic [7:0] next_voltage_source_control;
    logic [7:0] next_reg_rdata;
    logic config_changed;

    // Reset to defaults; any written code is stored as is
    always_comb begin
        next_sample_rate_config = sample_rate_config;
        next_voltage_source_control = voltage_source_control;
        next_reg_rdata = reg_rdata;
        config_changed = 1'b0;
        if (reg_write && reg_addr == adc_cfg_pkg::SAMPLE_RATE_CONFIG_ADDR) begin
            next_sample_rate_config = reg_wdata; // see (R14)
            config_changed = (reg_wdata != sample_rate_config);
        end
        if (reg_write && reg_addr == adc_cfg_pkg::VOLTAGE_SOURCE_CONTROL_ADDR) begin
            next_voltage_source_control = reg_wdata; // see (R14)
            config_changed = (reg_wdata != voltage_source_control);
        end
        if (reg_read) begin
            unique case (reg_addr)
                adc_cfg_pkg::SAMPLE_RATE_CONFIG_ADDR: next_reg_rdata = sample_rate_config;
                adc_cfg_pkg::VOLTAGE_SOURCE_CONTROL_ADDR: next_reg_rdata = voltage_source_control;
                default: next_reg_rdata = 8'h00; // Other registers live elsewhere
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sample_rate_config <= adc_cfg_pkg::SAMPLE_RATE_CONFIG_RESET; // see (R14)
            voltage_source_control <= adc_cfg_pkg::VOLTAGE_SOURCE_CONTROL_RESET;
            reg_rdata <= 8'h00;
        end else begin
            sample_rate_config <= next_sample_rate_config;
            voltage_source_control <= next_voltage_source_control;
            reg_rdata <= next_reg_rdata;
        end
    end

    // Field views
    logic chop_enable;
    logic single_shot;
    logic [3:0] rate_code;
    logic [1:0] monitor_code;
    logic [1:0] source_code;
    logic [1:0] power_code;
    logic mod_tick;

    assign chop_enable = sample_rate_config[adc_cfg_pkg::CHOP_BIT];
    assign single_shot = sample_rate_config[adc_cfg_pkg::CONV_MODE_BIT]; // see (R3)
    assign rate_code = sample_rate_config[adc_cfg_pkg::RATE_MSB:adc_cfg_pkg::RATE_LSB];
    assign monitor_code = voltage_source_control[adc_cfg_pkg::MONITOR_MSB:adc_cfg_pkg::MONITOR_LSB];
    assign source_code = voltage_source_control[adc_cfg_pkg::SOURCE_MSB:adc_cfg_pkg::SOURCE_LSB];
    assign power_code = voltage_source_control[adc_cfg_pkg::POWER_MSB:adc_cfg_pkg::POWER_LSB];

    // Modulator rate follows the chosen clock source
    assign external_clock_select = sample_rate_config[adc_cfg_pkg::CLOCK_SOURCE_BIT]; // see (R2)
    assign mod_tick = external_clock_select ? external_mod_tick : internal_mod_tick; // see (R2)
    assign low_latency_filter = sample_rate_config[adc_cfg_pkg::FILTER_BIT]; // see (R4)

    // Reference decode; reserved codes select nothing rather than guess
    assign low_threshold_monitor = (monitor_code != adc_cfg_pkg::MONITOR_OFF); // see (R6)
    assign third_span_monitor = (monitor_code == adc_cfg_pkg::MONITOR_LOW_THIRD); // see (R6)
    assign pull_together_enable = (monitor_code == adc_cfg_pkg::MONITOR_LOW_PULL); // see (R6)
    assign positive_buffer_bypass = voltage_source_control[adc_cfg_pkg::POS_BYPASS_BIT]; // see (R7)
    assign negative_buffer_bypass = voltage_source_control[adc_cfg_pkg::NEG_BYPASS_BIT]; // see (R8)
    assign ref_pair0_select = (source_code == adc_cfg_pkg::SOURCE_PAIR0); // see (R9)
    assign ref_pair1_select = (source_code == adc_cfg_pkg::SOURCE_PAIR1); // see (R9)
    assign internal_ref_select = (source_code == adc_cfg_pkg::SOURCE_INTERNAL); // see (R9)
    // Excitation sources depend on this level being on
    assign internal_source_on = (power_code == adc_cfg_pkg::POWER_ALWAYS_ON) ||
        (power_code == adc_cfg_pkg::POWER_ON_SLEEPS && !power_down); // see (R10) (R11)

    // Conversion period for a rate code; reserved code runs at the top rate
    function automatic logic [adc_cfg_pkg::PERIOD_W-1:0] rate_period(input logic [3:0] code);
        rate_period = adc_cfg_pkg::RATE_PERIOD[code];
    endfunction : rate_period

    // Sequencer state
    adc_cfg_pkg::seq_state_t state;
    adc_cfg_pkg::seq_state_t next_state;
    logic [adc_cfg_pkg::PERIOD_W-1:0] tick_count;
    logic [adc_cfg_pkg::PERIOD_W-1:0] next_tick_count;
    logic next_input_swap;
    logic pair_half;
    logic next_pair_half;
    logic signed [DATA_W-1:0] first_reading;
    logic signed [DATA_W-1:0] next_first_reading;
    logic next_data_ready;
    logic signed [DATA_W-1:0] next_conv_data;
    logic next_filter_reset;
    logic signed [DATA_W-1:0] corrected;
    logic signed [DATA_W:0] pair_sum;
    logic period_done;
    logic result_out;

    // Swapped readings are negated so the offset cancels in the sum
    assign corrected = input_swap ? -filter_data : filter_data; // see (R1)
    assign pair_sum = {first_reading[DATA_W-1], first_reading} + {corrected[DATA_W-1], corrected};
    assign period_done = mod_tick && (tick_count == 17'h00001);
    assign converting = (state != adc_cfg_pkg::SEQ_IDLE);

    always_comb begin
        next_state = state;
        next_tick_count = tick_count;
        next_input_swap = input_swap;
        next_pair_half = pair_half;
        next_first_reading = first_reading;
        next_data_ready = 1'b0;
        next_conv_data = conv_data;
        next_filter_reset = 1'b0;
        result_out = 1'b0;
        unique case (state)
            adc_cfg_pkg::SEQ_IDLE: begin
                if (conv_start) begin
                    next_state = adc_cfg_pkg::SEQ_DELAY;
                    next_tick_count = {4'h0, adc_cfg_pkg::START_DELAY[conv_delay_code]};
                    next_filter_reset = 1'b1;
                    next_input_swap = 1'b0;
                    next_pair_half = 1'b0;
                end
            end
            adc_cfg_pkg::SEQ_DELAY: begin
                // First result only after the programmed conversion delay
                if (mod_tick) begin
                    if (tick_count == 17'h00001) begin
                        next_state = adc_cfg_pkg::SEQ_CONVERT; // see (R13)
                        next_tick_count = rate_period(rate_code); // see (R5)
                    end else begin
                        next_tick_count = tick_count - 17'h00001;
                    end
                end
            end
            adc_cfg_pkg::SEQ_CONVERT: begin
                if (mod_tick) begin
                    next_tick_count = period_done ? rate_period(rate_code) : tick_count - 17'h00001; // see (R5)
                end
                if (period_done) begin
                    if (chop_enable) begin
                        // Pair of readings with opposite polarity
                        next_input_swap = !input_swap; // see (R1)
                        next_pair_half = !pair_half;
                        if (!pair_half) begin
                            next_first_reading = corrected;
                        end else begin
                            next_conv_data = pair_sum[DATA_W:1]; // see (R1)
                            next_data_ready = 1'b1;
                            result_out = 1'b1;
                        end
                    end else begin
                        next_conv_data = filter_data;
                        next_data_ready = 1'b1;
                        result_out = 1'b1;
                    end
                    // Single-shot halts after its one result
                    if (result_out && single_shot) begin
                        next_state = adc_cfg_pkg::SEQ_IDLE; // see (R3)
                    end
                end
            end
            default: next_state = adc_cfg_pkg::SEQ_IDLE; // Code 10 is illegal
        endcase
        // Restart on config change wins over a result in the same cycle
        if (config_changed && state != adc_cfg_pkg::SEQ_IDLE) begin
            next_state = adc_cfg_pkg::SEQ_DELAY; // see (R13)
            next_tick_count = {4'h0, adc_cfg_pkg::START_DELAY[conv_delay_code]};
            next_filter_reset = 1'b1; // see (R13)
            next_input_swap = 1'b0;
            next_pair_half = 1'b0;
            next_data_ready = 1'b0;
            next_conv_data = conv_data;
        end
        // Stop and power-down end conversions outright
        if (conv_stop || power_down) begin
            next_state = adc_cfg_pkg::SEQ_IDLE;
            next_input_swap = 1'b0;
            next_pair_half = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= adc_cfg_pkg::SEQ_IDLE;
            tick_count <= 17'h00000;
            input_swap <= 1'b0;
            pair_half <= 1'b0;
            first_reading <= '0;
            data_ready <= 1'b0;
            conv_data <= '0;
            filter_reset <= 1'b0;
        end else begin
            state <= next_state;
            tick_count <= next_tick_count;
            input_swap <= next_input_swap;
            pair_half <= next_pair_half;
            first_reading <= next_first_reading;
            data_ready <= next_data_ready;
            conv_data <= next_conv_data;
            filter_reset <= next_filter_reset;
        end
    end

endmodule : adc_rate_and_vref_config

// [verilog/adc_cfg_pkg.sv]
/*
 * Constants for the converter rate and reference configuration block:
 * register addresses, field positions, reset values, timing tables.
 * Assumes a 5-bit register address from the serial command decoder.
 */
package adc_cfg_pkg;
    localparam int ADDR_W = 5;
    localparam logic [4:0] SAMPLE_RATE_CONFIG_ADDR = 5'h04;
    localparam logic [4:0] VOLTAGE_SOURCE_CONTROL_ADDR = 5'h05;
    localparam logic [7:0] SAMPLE_RATE_CONFIG_RESET = 8'h14;
    localparam logic [7:0] VOLTAGE_SOURCE_CONTROL_RESET = 8'h10;

    // Sample rate config fields
    localparam int CHOP_BIT = 7;
    localparam int CLOCK_SOURCE_BIT = 6;
    localparam int CONV_MODE_BIT = 5;
    localparam int FILTER_BIT = 4;
    localparam int RATE_MSB = 3;
    localparam int RATE_LSB = 0;

    // Voltage source control fields
    localparam int MONITOR_MSB = 7;
    localparam int MONITOR_LSB = 6;
    localparam int POS_BYPASS_BIT = 5;
    localparam int NEG_BYPASS_BIT = 4;
    localparam int SOURCE_MSB = 3;
    localparam int SOURCE_LSB = 2;
    localparam int POWER_MSB = 1;
    localparam int POWER_LSB = 0;

    localparam logic [1:0] MONITOR_OFF = 2'h0;
    localparam logic [1:0] MONITOR_LOW = 2'h1;
    localparam logic [1:0] MONITOR_LOW_THIRD = 2'h2;
    localparam logic [1:0] MONITOR_LOW_PULL = 2'h3;
    localparam logic [1:0] SOURCE_PAIR0 = 2'h0;
    localparam logic [1:0] SOURCE_PAIR1 = 2'h1;
    localparam logic [1:0] SOURCE_INTERNAL = 2'h2;
    localparam logic [1:0] POWER_OFF = 2'h0;
    localparam logic [1:0] POWER_ON_SLEEPS = 2'h1;
    localparam logic [1:0] POWER_ALWAYS_ON = 2'h2;

    // Conversion period in modulator ticks, 256 kHz modulator rate
    localparam int PERIOD_W = 17;
    localparam logic [16:0] RATE_PERIOD [16] = '{
        17'h19000, 17'h0c800, 17'h06400, 17'h03c00,
        17'h03200, 17'h01400, 17'h010aa, 17'h00a00,
        17'h00500, 17'h00280, 17'h00140, 17'h00100,
        17'h00080, 17'h00040, 17'h00040, 17'h00040
    };

    // First-conversion delay in modulator ticks, by delay code
    localparam int DELAY_W = 13;
    localparam logic [12:0] START_DELAY [8] = '{
        13'h000e, 13'h0019, 13'h0040, 13'h0100,
        13'h0400, 13'h0800, 13'h1000, 13'h0001
    };

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_DELAY = 2'b01,
        SEQ_CONVERT = 2'b11
    } seq_state_t;
endpackage : adc_cfg_pkg

// [dv/adc_rate_and_vref_config_assertions.sv]
/*
 * Port checker for the rate and reference configuration block.
 * Assumes one clock, synchronous active-low reset, one-cycle write strobes.
 */
`timescale 1ns/1ps
module adc_cfg_checker (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic [adc_cfg_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic conv_start,
    input wire logic conv_stop,
    input wire logic power_down,
    input wire logic external_clock_select,
    input wire logic low_latency_filter,
    input wire logic filter_reset,
    input wire logic converting,
    input wire logic data_ready,
    input wire logic low_threshold_monitor,
    input wire logic third_span_monitor,
    input wire logic pull_together_enable,
    input wire logic positive_buffer_bypass,
    input wire logic negative_buffer_bypass,
    input wire logic ref_pair0_select,
    input wire logic ref_pair1_select,
    input wire logic internal_ref_select,
    input wire logic internal_source_on
);
    logic w04;
    logic w05;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Write strobes per register
    assign w04 = reg_write && reg_addr == adc_cfg_pkg::SAMPLE_RATE_CONFIG_ADDR;
    assign w05 = reg_write && reg_addr == adc_cfg_pkg::VOLTAGE_SOURCE_CONTROL_ADDR;

    chk_rate_fields: assert property (w04 |=> external_clock_select == $past(reg_wdata[6])
        && low_latency_filter == $past(reg_wdata[4])) else $error("rate fields not decoded");
    chk_buffer_bits: assert property (w05 |=> positive_buffer_bypass == $past(reg_wdata[5])
        && negative_buffer_bypass == $past(reg_wdata[4])) else $error("buffer bits wrong");
    chk_monitor_code: assert property (w05 |=> low_threshold_monitor == ($past(reg_wdata[7:6]) != 2'h0)
        && third_span_monitor == ($past(reg_wdata[7:6]) == 2'h2)
        && pull_together_enable == ($past(reg_wdata[7:6]) == 2'h3)) else $error("monitor decode wrong");
    chk_source_code: assert property (w05 |=> {ref_pair0_select, ref_pair1_select, internal_ref_select}
        == {$past(reg_wdata[3:2]) == 2'h0, $past(reg_wdata[3:2]) == 2'h1, $past(reg_wdata[3:2]) == 2'h2})
        else $error("source decode wrong");
    chk_power_code: assert property (w05 |=> internal_source_on == ($past(reg_wdata[1:0]) == 2'h2
        || ($past(reg_wdata[1:0]) == 2'h1 && !power_down))) else $error("power decode wrong");
    chk_reset_cause: assert property (filter_reset |-> $past(conv_start || reg_write))
        else $error("filter reset without cause");
    chk_start_reset: assert property (conv_start && !converting && !conv_stop && !power_down
        |=> filter_reset && converting) else $error("start did not reset filter");
    chk_stop_idle: assert property ((conv_stop || power_down) && !conv_start && !reg_write
        |=> !converting) else $error("stop did not idle");
    chk_ready_pulse: assert property (data_ready |=> !data_ready [*8])
        else $error("results too close");

    cover property (data_ready);
    cover property (filter_reset && converting);
    cover property (w05 ##1 internal_source_on);
endmodule : adc_cfg_checker

bind adc_rate_and_vref_config adc_cfg_checker u_chk (.clk, .reset_n, .reg_write, .reg_addr, .reg_wdata,
    .conv_start, .conv_stop, .power_down, .external_clock_select, .low_latency_filter, .filter_reset,
    .converting, .data_ready, .low_threshold_monitor, .third_span_monitor, .pull_together_enable,
    .positive_buffer_bypass, .negative_buffer_bypass, .ref_pair0_select, .ref_pair1_select,
    .internal_ref_select, .internal_source_on);

// [dv/host_model.sv]
/*
 * Host controller model issuing register commands.
 * Assumes strobes sampled on rising clk; drives on falling edges only.
 */
`timescale 1ns/1ps
module host_model (
    input wire logic clk,
    output logic reg_write,
    output logic reg_read,
    output logic [adc_cfg_pkg::ADDR_W-1:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // Idle command port
    initial begin
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 8'h00;
    end
    // Released lines show the inverse so stale values never look valid
    task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clk);
        reg_write = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : write_reg
    task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clk);
        d = reg_rdata;
        reg_read = 1'b0;
        reg_addr = ~a;
    endtask : read_reg
    // Internal source powered and both buffers bypassed, before any excitation use
    task automatic use_internal_source;
        write_reg(5'h05, 8'h3a);
    endtask : use_internal_source
endmodule : host_model

// [dv/adc_rate_and_vref_config_tb_top.sv]
/*
 * Self-checking bench: register access, decodes, conversion timing.
 * Assumes a modulator tick every clock, first-conversion delay of one tick.
 */
`timescale 1ns/1ps
module adc_rate_and_vref_config_tb_top;
    logic clk, reset_n, reg_write, reg_read, conv_start, conv_stop, power_down;
    logic internal_mod_tick, external_mod_tick, external_clock_select, low_latency_filter, filter_reset;
    logic input_swap, converting, data_ready, low_threshold_monitor, third_span_monitor, pull_together_enable;
    logic positive_buffer_bypass, negative_buffer_bypass, ref_pair0_select, ref_pair1_select;
    logic internal_ref_select, internal_source_on;
    logic [adc_cfg_pkg::ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rd, v;
    logic [2:0] conv_delay_code;
    logic signed [15:0] filter_data, conv_data;
    int fails, checked, cycles, gap;

    host_model u_host (.clk, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata);
    adc_rate_and_vref_config u_dut (.clk, .reset_n, .reg_write, .reg_read, .reg_addr, .reg_wdata, .reg_rdata,
        .conv_start, .conv_stop, .power_down, .conv_delay_code, .internal_mod_tick, .external_mod_tick,
        .filter_data, .external_clock_select, .low_latency_filter, .filter_reset, .input_swap, .converting,
        .data_ready, .conv_data, .low_threshold_monitor, .third_span_monitor, .pull_together_enable,
        .positive_buffer_bypass, .negative_buffer_bypass, .ref_pair0_select, .ref_pair1_select,
        .internal_ref_select, .internal_source_on);

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task complete_run;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // Bounded wait for a result; n is cycles waited since the call
    task automatic wait_ready(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (data_ready !== 1'b1 && n < 3000);
        if (n >= 3000) fails++;
    endtask : wait_ready

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard, well above the expected run of under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run;
        end
    end
    // Input with opposite sign when swapped, so chop averaging is visible
    always @(negedge clk) filter_data <= input_swap ? -16'sh012c : 16'sh01f4;

    initial begin
        {reset_n, conv_start, conv_stop, power_down, external_mod_tick} = 5'h00;
        internal_mod_tick = 1'b1;
        conv_delay_code = 3'h7;
        filter_data = 16'sh01f4;
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        u_host.read_reg(5'h04, rd);
        check("rate reset", 16'h0014, rd);
        u_host.read_reg(5'h05, rd);
        check("ref reset", 16'h0010, rd);
        check("defaults", 16'h0009, {low_latency_filter, external_clock_select, positive_buffer_bypass,
            negative_buffer_bypass});
        check("pair default", 1, ref_pair0_select);
        $display("test defaults done");
        for (int i = 0; i < 4; i++) begin
            v = {i[1:0], i[0], ~i[0], i[1:0], i[1:0]};
            u_host.write_reg(5'h05, v);
            check("monitor", {i != 0, i == 2, i == 3}, {low_threshold_monitor, third_span_monitor,
                pull_together_enable});
            check("buffers", {i[0], ~i[0]}, {positive_buffer_bypass, negative_buffer_bypass});
            check("source", {i == 0, i == 1, i == 2}, {ref_pair0_select, ref_pair1_select,
                internal_ref_select});
            check("power", i == 2 || i == 1, internal_source_on);
            power_down = 1'b1;
            @(negedge clk);
            check("power sleep", i == 2, internal_source_on);
            power_down = 1'b0;
            u_host.read_reg(5'h05, rd);
            check("ref readback", v, rd);
        end
        u_host.write_reg(5'h04, 8'h40);
        check("clock ext", 16'h0002, {external_clock_select, low_latency_filter});
        u_host.read_reg(5'h07, rd);
        check("unmapped", 0, rd);
        u_host.use_internal_source();
        check("source on", 1, internal_source_on);
        $display("test registers done");
        @(negedge clk);
        conv_start = 1'b1;
        @(negedge clk);
        conv_start = 1'b0;
        check("start reset", 1, filter_reset);
        for (int k = 0; k < 2; k++) begin
            u_host.write_reg(5'h04, {4'h0, 4'hc + k[3:0]});
            check("write restart", 1, filter_reset);
            wait_ready(gap);
            wait_ready(gap);
            check("period", 16'h0080 >> k, gap[15:0]);
            check("plain data", 16'h01f4, conv_data);
        end
        u_host.write_reg(5'h04, 8'h8d);
        wait_ready(gap);
        check("chop avg", 16'h0190, conv_data);
        wait_ready(gap);
        check("chop period", 16'h0080, gap[15:0]);
        u_host.write_reg(5'h04, 8'h2d);
        wait_ready(gap);
        @(negedge clk);
        check("single shot", 0, converting);
        // External clock path, then a stop in mid-run
        internal_mod_tick = 1'b0;
        external_mod_tick = 1'b1;
        u_host.write_reg(5'h04, 8'h4d);
        conv_start = 1'b1;
        @(negedge clk);
        conv_start = 1'b0;
        wait_ready(gap);
        wait_ready(gap);
        check("ext period", 16'h0040, gap[15:0]);
        conv_stop = 1'b1;
        @(negedge clk);
        conv_stop = 1'b0;
        check("stopped", 0, converting);
        $display("test conversions done");
        complete_run;
    end
endmodule : adc_rate_and_vref_config_tb_top
